// >>> pkg/scm_pkg.sv
// What this block does
// RQ1: Mode from three-bit field plus select bit
// RQ2: Mode 0 receive pin; transmit pin or divider
// RQ3: Mode 0b drives divider clock on pin
// RQ4: Mode 1 clocks both directions from receive pin
// RQ5: Mode 1 strobes gate each bit
// RQ6: Mode 1 transparent: one strobe moves byte
// RQ7: Mode 2 divider from receive pin feeds recovery
// RQ8: Mode 2 transmit: pin or divider over 16
// RQ9: Mode 3a recovery clocks both directions
// RQ10: Mode 3b divider clocks both directions directly
// RQ11: Mode 4 gates suppress inactive bit periods
// RQ12: Mode 5 sync inputs; 5a slot output
// RQ13: Mode 6b transmit is oscillator divider over 16
// RQ14: Mode 6 receive is recovery output
// RQ15: Output enable drives effective transmit clock out
// RQ16: Software powers oscillator for 0b, 6, 7
// RQ17: Oscillator shared; divider and recovery per channel
// RQ18: Crystal input accepts external clock
// RQ19: Modes 7a/7b like 3a/3b from crystal
// RQ20: Mode 5a pin low during transmit slot
// RQ21: Transmit pin input unless output defined and enabled
// RQ22: Select bit ignored in modes 1 and 4
package scm_pkg;

  localparam int unsigned REC_DIV      = 16;
  localparam int unsigned BYTE_BITS    = 8;
  localparam int unsigned RATIO_W      = 16;

  // Register byte offsets
  localparam logic [3:0] OFS_CONFIG    = 4'h0;
  localparam logic [3:0] OFS_GLOBAL    = 4'h4;
  localparam logic [3:0] OFS_RATIO     = 4'h8;
  localparam logic [3:0] OFS_STATUS    = 4'hC;

  // Field positions in channel_config_low_reg
  localparam int unsigned FLD_MODE_LSB = 0;
  localparam int unsigned FLD_SEL      = 3;
  localparam int unsigned FLD_OUT_EN   = 4;
  localparam int unsigned FLD_XPAR     = 5;
  // Field position in global_setup_reg
  localparam int unsigned FLD_OSC_PD   = 0;

  // Reset values
  localparam logic [2:0]         RST_MODE  = 3'h0;
  localparam logic               RST_OSCILLATOR_POWERDOWN_BIT = 1'b1;
  localparam logic [RATIO_W-1:0] RST_RATIO = 16'h0000;

  // Combined mode code {mode field, select bit}
  typedef enum logic [3:0] {
    MODE_0A = 4'b0000, MODE_0B = 4'b0001,
    MODE_1A = 4'b0010, MODE_1B = 4'b0011,
    MODE_2A = 4'b0100, MODE_2B = 4'b0101,
    MODE_3A = 4'b0110, MODE_3B = 4'b0111,
    MODE_4A = 4'b1000, MODE_4B = 4'b1001,
    MODE_5A = 4'b1010, MODE_5B = 4'b1011,
    MODE_6A = 4'b1100, MODE_6B = 4'b1101,
    MODE_7A = 4'b1110, MODE_7B = 4'b1111
  } scm_mode_t;

  // Channel configuration bundle
  typedef struct packed {
    logic       xpar;
    logic       tx_pin_out_en;
    logic       sel;
    logic [2:0] clock_mode_field;
  } scm_cfg_t;

  // A derived clock: its level and a one-cycle rising-edge tick
  typedef struct packed {
    logic level;
    logic tick;
  } scm_clk_t;

endpackage

// >>> rtl/scm_rate_divider.sv
`timescale 1ns/1ns
// Programmable divider: output toggles every (ratio+1) source ticks
module scm_rate_divider
  import scm_pkg::*;
#(
  parameter int unsigned W = RATIO_W
) (
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic         clk_en_in,
  input  wire logic         src_tick_in,
  input  wire logic [W-1:0] ratio_in,
  output scm_clk_t          clk_out
);

  logic [W-1:0] count;
  logic         level;

  // Count source ticks, toggle the output at the terminal count
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= '0;
      level <= 1'b0;
    end else if (clk_en_in && src_tick_in) begin
      if (count >= ratio_in) begin
        count <= '0;
        level <= ~level;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // Tick marks the rising edge of the output
  assign clk_out.level = level;
  assign clk_out.tick  = clk_en_in && src_tick_in && (count >= ratio_in) && !level;

endmodule // scm_rate_divider

// >>> rtl/scm_div16.sv
`timescale 1ns/1ns
// Divide-by-16 with optional phase realignment on data edges
module scm_div16
  import scm_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  input  wire logic ref_tick_in,
  input  wire logic resync_in,
  output scm_clk_t  clk_out
);

  localparam int unsigned CW = $clog2(REC_DIV);
  localparam logic [CW-1:0] MID = CW'(REC_DIV / 2);

  logic [CW-1:0] phase;

  // Phase counter; a data edge pulls the phase to mid-cell
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase <= '0;
    end else if (clk_en_in) begin
      if (resync_in) begin
        phase <= MID;
      end else if (ref_tick_in) begin
        phase <= phase + 1'b1;
      end
    end
  end

  assign clk_out.level = phase[CW-1];
  assign clk_out.tick  = clk_en_in && ref_tick_in && !resync_in && (phase == (MID - 1'b1));

endmodule // scm_div16

// >>> rtl/scm_clock_mode_select.sv
`timescale 1ns/1ns
// Per-channel clock source selection with Avalon-MM register access
module scm_clock_mode_select
  import scm_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial pins
  input  wire logic        rx_clock_pin_in,
  input  wire logic        tx_clock_pin_in,
  output logic             tx_clock_pin_out,
  output logic             tx_clock_pin_oe_out,
  input  wire logic        crystal_in_pin_in,
  output logic             crystal_out_pin_out,
  input  wire logic        carrier_detect_pin_in,
  input  wire logic        rx_gate_pin_in,
  input  wire logic        tx_gate_pin_in,
  input  wire logic        frame_sync_pin_in,
  input  wire logic        tx_octet_sync_pin_in,
  input  wire logic        rx_octet_sync_pin_in,
  input  wire logic        rx_data_pin_in,
  // Slot assigner windows, same clock domain
  input  wire logic        rx_slot_active_in,
  input  wire logic        tx_slot_active_in,
  // Protocol side
  output logic             rx_bit_en_out,
  output logic             tx_bit_en_out,
  output logic             rx_sync_out,
  output logic             tx_sync_out,
  output logic             carrier_detect_out
);

  localparam int unsigned NPIN = 10;
  localparam int unsigned BCW  = $clog2(BYTE_BITS);

  // Pin synchronisers: two flops before any logic
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_last;

  assign pin_raw = {rx_data_pin_in, rx_octet_sync_pin_in, tx_octet_sync_pin_in,
                    frame_sync_pin_in, tx_gate_pin_in, rx_gate_pin_in,
                    carrier_detect_pin_in, crystal_in_pin_in, tx_clock_pin_in,
                    rx_clock_pin_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          pin_last[gi] <= 1'b0;
        end else if (clk_en_in) begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_last[gi] <= pin_sync[gi];
        end
      end
    end
  endgenerate

  logic [NPIN-1:0] pin_rise;
  assign pin_rise = pin_sync & ~pin_last & {NPIN{clk_en_in}};

  // Registers
  scm_cfg_t            channel_config_low_reg;
  logic                oscillator_powerdown_bit;
  logic [RATIO_W-1:0]  divider_ratio;
  logic                bus_ack;
  scm_mode_t           mode;

  assign mode = scm_mode_t'({channel_config_low_reg.clock_mode_field,
                             channel_config_low_reg.sel});  // [RQ1]

  // Bus handshake: one wait cycle, request taken on the second edge
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_ack <= 1'b0;
    end else if (clk_en_in) begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !(bus_ack && clk_en_in);

  logic bus_wr;
  logic bus_rd;
  assign bus_wr = avs_write && bus_ack && clk_en_in;
  assign bus_rd = avs_read && !bus_ack && clk_en_in;

  // Configuration register writes
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      channel_config_low_reg   <= '{xpar: 1'b0, tx_pin_out_en: 1'b0, sel: 1'b0,
                                    clock_mode_field: RST_MODE};
      oscillator_powerdown_bit <= RST_OSCILLATOR_POWERDOWN_BIT;
      divider_ratio            <= RST_RATIO;
    end else if (bus_wr) begin
      if (avs_address == OFS_CONFIG && avs_byteenable[0]) begin
        channel_config_low_reg.clock_mode_field <= avs_writedata[FLD_MODE_LSB +: 3];
        channel_config_low_reg.sel              <= avs_writedata[FLD_SEL];
        channel_config_low_reg.tx_pin_out_en    <= avs_writedata[FLD_OUT_EN];
        channel_config_low_reg.xpar             <= avs_writedata[FLD_XPAR];
      end
      if (avs_address == OFS_GLOBAL && avs_byteenable[0]) begin
        oscillator_powerdown_bit <= avs_writedata[FLD_OSC_PD];  // [RQ16]
      end
      if (avs_address == OFS_RATIO) begin
        if (avs_byteenable[0]) begin
          divider_ratio[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          divider_ratio[15:8] <= avs_writedata[15:8];
        end
      end
    end
  end

  // Oscillator: crystal pin edges, external clock or crystal alike
  logic osc_tick;
  assign osc_tick = pin_rise[2] && !oscillator_powerdown_bit;  // [RQ18]

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      crystal_out_pin_out <= 1'b0;
    end else if (clk_en_in) begin
      crystal_out_pin_out <= !oscillator_powerdown_bit && !pin_sync[2];
    end
  end

  // Divider source per mode
  logic brg_src_tick;
  always_comb begin
    case (mode)
      MODE_0B, MODE_6A, MODE_6B,
      MODE_7A, MODE_7B: brg_src_tick = osc_tick;     // [RQ2] [RQ13] [RQ19]
      MODE_2A, MODE_2B,
      MODE_3A, MODE_3B: brg_src_tick = pin_rise[0];  // [RQ7] [RQ9] [RQ10]
      default:          brg_src_tick = 1'b0;
    endcase
  end

  // Own divider and recovery per channel; oscillator may be shared
  scm_clk_t brg_clk;
  scm_clk_t clock_recovery_loop_clk;
  scm_clk_t brg16_clk;
  logic     rx_data_edge;

  assign rx_data_edge = pin_sync[9] ^ pin_last[9];

  scm_rate_divider #(.W(RATIO_W)) u_rate_divider (  // [RQ17]
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .clk_en_in   (clk_en_in),
    .src_tick_in (brg_src_tick),
    .ratio_in    (divider_ratio),
    .clk_out     (brg_clk)
  );

  // Recovery loop: divider output at 16 times bit rate
  scm_div16 u_clock_recovery_loop (  // [RQ7] [RQ14]
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .clk_en_in   (clk_en_in),
    .ref_tick_in (brg_clk.tick),
    .resync_in   (rx_data_edge && clk_en_in),
    .clk_out     (clock_recovery_loop_clk)
  );

  // Plain divide by 16 for transmit in 2b and 6b
  scm_div16 u_tx_div16 (  // [RQ8] [RQ13]
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .clk_en_in   (clk_en_in),
    .ref_tick_in (brg_clk.tick),
    .resync_in   (1'b0),
    .clk_out     (brg16_clk)
  );

  scm_clk_t rxp_clk;
  scm_clk_t txp_clk;
  assign rxp_clk = '{level: pin_sync[0], tick: pin_rise[0]};
  assign txp_clk = '{level: pin_sync[1], tick: pin_rise[1]};

  // Receive and transmit domain clock selection
  scm_clk_t rx_domain_clock;
  scm_clk_t tx_domain_clock;
  always_comb begin
    case (mode)
      MODE_0A, MODE_0B,
      MODE_1A, MODE_1B,
      MODE_4A, MODE_4B,
      MODE_5A, MODE_5B: rx_domain_clock = rxp_clk;  // [RQ2] [RQ4] [RQ22]
      MODE_3B, MODE_7B: rx_domain_clock = brg_clk;  // [RQ10] [RQ19]
      default:          rx_domain_clock = clock_recovery_loop_clk; // [RQ7] [RQ9] [RQ14]
    endcase
    case (mode)
      MODE_1A, MODE_1B,
      MODE_5A:          tx_domain_clock = rxp_clk;    // [RQ4] [RQ22]
      MODE_0B, MODE_3B,
      MODE_7B:          tx_domain_clock = brg_clk;    // [RQ2] [RQ10] [RQ19]
      MODE_2B, MODE_6B: tx_domain_clock = brg16_clk;  // [RQ8] [RQ13]
      MODE_3A, MODE_7A: tx_domain_clock = clock_recovery_loop_clk;   // [RQ9] [RQ19]
      default:          tx_domain_clock = txp_clk;    // [RQ2] [RQ8] [RQ11]
    endcase
  end

  // Strobes, gates and slot windows per direction
  logic rx_allow;
  logic tx_allow;
  always_comb begin
    case (mode)
      MODE_1A, MODE_1B: begin
        rx_allow = pin_sync[3];  // [RQ5]
        tx_allow = pin_sync[1];  // [RQ5]
      end
      MODE_4A, MODE_4B: begin
        rx_allow = pin_sync[4];  // [RQ11]
        tx_allow = pin_sync[5];  // [RQ11]
      end
      MODE_5A, MODE_5B: begin
        rx_allow = rx_slot_active_in;  // [RQ12]
        tx_allow = tx_slot_active_in;  // [RQ12]
      end
      default: begin
        rx_allow = 1'b1;
        tx_allow = 1'b1;
      end
    endcase
  end

  // Byte runs in transparent mode 1: one strobe moves eight bits
  logic [BCW-1:0] rx_byte_cnt;
  logic [BCW-1:0] tx_byte_cnt;
  logic           rx_in_byte;
  logic           tx_in_byte;
  logic           byte_mode;
  logic           rx_go;
  logic           tx_go;

  assign byte_mode = channel_config_low_reg.xpar &&
                     (mode == MODE_1A || mode == MODE_1B);
  assign rx_go = rx_domain_clock.tick && (byte_mode ? (rx_in_byte || rx_allow) : rx_allow);
  assign tx_go = tx_domain_clock.tick && (byte_mode ? (tx_in_byte || tx_allow) : tx_allow);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_byte_cnt <= '0;
      rx_in_byte  <= 1'b0;
    end else if (clk_en_in) begin
      if (!byte_mode) begin
        rx_in_byte  <= 1'b0;
        rx_byte_cnt <= '0;
      end else if (rx_go) begin
        rx_byte_cnt <= rx_byte_cnt + 1'b1;                        // [RQ6]
        rx_in_byte  <= (rx_byte_cnt != BCW'(BYTE_BITS - 1));      // [RQ6]
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_byte_cnt <= '0;
      tx_in_byte  <= 1'b0;
    end else if (clk_en_in) begin
      if (!byte_mode) begin
        tx_in_byte  <= 1'b0;
        tx_byte_cnt <= '0;
      end else if (tx_go) begin
        tx_byte_cnt <= tx_byte_cnt + 1'b1;                        // [RQ6]
        tx_in_byte  <= (tx_byte_cnt != BCW'(BYTE_BITS - 1));      // [RQ6]
      end
    end
  end

  // Registered protocol-side outputs
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_bit_en_out      <= 1'b0;
      tx_bit_en_out      <= 1'b0;
      rx_sync_out        <= 1'b0;
      tx_sync_out        <= 1'b0;
      carrier_detect_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_bit_en_out <= rx_go;  // [RQ5] [RQ11]
      tx_bit_en_out <= tx_go;  // [RQ5] [RQ11]
      rx_sync_out   <= (mode == MODE_5A) ? pin_rise[6] :
                       (mode == MODE_5B) ? pin_rise[8] : 1'b0;  // [RQ12]
      tx_sync_out   <= (mode == MODE_5A) ? pin_rise[6] :
                       (mode == MODE_5B) ? pin_rise[7] : 1'b0;      // [RQ12]
      carrier_detect_out <= (mode == MODE_1A || mode == MODE_1B ||
                             mode == MODE_4A || mode == MODE_4B ||
                             mode == MODE_5A || mode == MODE_5B) ? 1'b0 : pin_sync[3];
    end
  end

  // Transmit clock pin: output only where a mode defines one
  logic pin_defined;
  logic pin_level;
  always_comb begin
    pin_defined = 1'b1;
    case (mode)
      MODE_0B, MODE_2B, MODE_3A, MODE_3B,
      MODE_6B, MODE_7A, MODE_7B: pin_level = tx_domain_clock.level;  // [RQ3] [RQ8] [RQ15]
      MODE_5A:                   pin_level = !tx_slot_active_in;     // [RQ20]
      default: begin
        pin_level   = 1'b0;
        pin_defined = 1'b0;                                          // [RQ21]
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_clock_pin_out    <= 1'b0;
      tx_clock_pin_oe_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_clock_pin_oe_out <= pin_defined && channel_config_low_reg.tx_pin_out_en;  // [RQ21]
      tx_clock_pin_out    <= pin_level;                                          // [RQ15]
    end
  end

  // Read data loaded one edge early, standing at the accepting edge
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      case (avs_address)
        OFS_CONFIG: avs_readdata <= {26'h000_0000, channel_config_low_reg};
        OFS_GLOBAL: avs_readdata <= {31'h0000_0000, oscillator_powerdown_bit};
        OFS_RATIO:  avs_readdata <= {16'h0000, divider_ratio};
        OFS_STATUS: avs_readdata <= {27'h000_0000, tx_clock_pin_oe_out,
                                     !oscillator_powerdown_bit,
                                     tx_domain_clock.level, rx_domain_clock.level,
                                     byte_mode};
        default:    avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // scm_clock_mode_select

// >>> verif/scm_clock_mode_select_monitor.sv
`timescale 1ns/1ns
// Pin and pulse checks at the block ports
module scm_clock_mode_select_monitor
  import scm_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        carrier_detect_pin_in,
  input wire logic        rx_gate_pin_in,
  input wire logic        tx_slot_active_in,
  input wire logic        tx_clock_pin_out,
  input wire logic        tx_clock_pin_oe_out,
  input wire logic        rx_bit_en_out,
  input wire logic        rx_sync_out,
  input wire logic        tx_sync_out,
  input wire logic        carrier_detect_out
);
  logic [5:0] cfg;
  logic [3:0] age;
  logic [3:0] cd_lo;
  logic [3:0] rg_lo;
  logic [3:0] code;
  logic       pin_mode;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Combined mode code and modes with a pin output
  assign code = {cfg[2:0], cfg[FLD_SEL]};
  assign pin_mode = code inside {MODE_0B, MODE_2B, MODE_3A, MODE_3B,
                                 MODE_5A, MODE_6B, MODE_7A, MODE_7B};
  // Shadow of accepted config writes, settle age
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg <= '0;
      age <= '0;
    end else if (avs_write && !avs_waitrequest && avs_address == OFS_CONFIG) begin
      cfg <= avs_writedata[5:0];
      age <= '0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end
  // Cycles the receive strobe and receive gate pins stayed low
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cd_lo <= '0;
      rg_lo <= '0;
    end else begin
      cd_lo <= carrier_detect_pin_in ? 4'h0 : cd_lo + 4'(cd_lo != 4'hF);
      rg_lo <= rx_gate_pin_in ? 4'h0 : rg_lo + 4'(rg_lo != 4'hF);
    end
  end
  a_oe_held_input: assert property (
    age > 4'h3 && !(pin_mode && cfg[FLD_OUT_EN]) |-> !tx_clock_pin_oe_out)
    else $error("tx pin driven, no output mode");
  a_oe_drive_out: assert property (
    age > 4'h3 && pin_mode && cfg[FLD_OUT_EN] |-> tx_clock_pin_oe_out)
    else $error("tx clock pin not driven in output mode");
  a_slot_pin_low: assert property (
    age > 4'h3 && code == MODE_5A && cfg[FLD_OUT_EN] && $stable(tx_slot_active_in)
    |-> tx_clock_pin_out == !tx_slot_active_in)
    else $error("slot level wrong on tx pin");
  a_cd_blanked: assert property (
    age > 4'h3 && cfg[2:0] inside {3'h1, 3'h4, 3'h5} |-> !carrier_detect_out)
    else $error("carrier passed in strobe mode");
  a_rx_strobe_gate: assert property (
    age > 4'h3 && cfg[2:0] == 3'h1 && !cfg[FLD_XPAR] && cd_lo > 4'h7 |-> !rx_bit_en_out)
    else $error("rx bit without strobe");
  a_rx_gate_off: assert property (
    age > 4'h3 && cfg[2:0] == 3'h4 && rg_lo > 4'h7 |-> !rx_bit_en_out)
    else $error("rx bit while gate inactive");
  a_bit_single: assert property (
    rx_bit_en_out |=> !rx_bit_en_out)
    else $error("rx bit pulse too long");
  a_sync_mode5: assert property (
    age > 4'h3 && (rx_sync_out || tx_sync_out) |-> cfg[2:0] == 3'h5)
    else $error("sync pulse outside sync modes");
endmodule // scm_clock_mode_select_monitor

bind scm_clock_mode_select scm_clock_mode_select_monitor u_scm_clock_mode_select_monitor (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .carrier_detect_pin_in(carrier_detect_pin_in), .rx_gate_pin_in(rx_gate_pin_in),
  .tx_slot_active_in(tx_slot_active_in), .tx_clock_pin_out(tx_clock_pin_out),
  .tx_clock_pin_oe_out(tx_clock_pin_oe_out), .rx_bit_en_out(rx_bit_en_out),
  .rx_sync_out(rx_sync_out), .tx_sync_out(tx_sync_out),
  .carrier_detect_out(carrier_detect_out)
);

// >>> verif/scm_pin_source.sv
`timescale 1ns/1ns
// Far-side clocks: receive pin, transmit pin, external crystal clock
module scm_pin_source #(
  parameter int RX_HALF = 2,
  parameter int TX_HALF = 5,
  parameter int XT_HALF = 3
) (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic run_in,
  output logic      rx_clk_out,
  output logic      tx_clk_out,
  output logic      xtal_out
);
  int rx_n, tx_n, xt_n;
  // Each pin toggles every half period; all stand still when not running
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {rx_n, tx_n, xt_n} <= '0;
      {rx_clk_out, tx_clk_out, xtal_out} <= 3'h0;
    end else if (run_in) begin
      rx_n <= (rx_n == RX_HALF - 1) ? 0 : rx_n + 1;
      tx_n <= (tx_n == TX_HALF - 1) ? 0 : tx_n + 1;
      xt_n <= (xt_n == XT_HALF - 1) ? 0 : xt_n + 1;
      if (rx_n == RX_HALF - 1) rx_clk_out <= !rx_clk_out;
      if (tx_n == TX_HALF - 1) tx_clk_out <= !tx_clk_out;
      if (xt_n == XT_HALF - 1) xtal_out <= !xtal_out;
    end
  end
endmodule // scm_pin_source

// >>> verif/scm_clock_mode_select_tb.sv
`timescale 1ns/1ns
// Register, mode table and pin checks for one channel
module scm_clock_mode_select_tb
  import scm_pkg::*;
;
  localparam logic [63:0] RX_MAP = 64'h2333_0000_4555_0000;
  localparam logic [63:0] TX_MAP = 64'h2331_1011_4551_0021;
  localparam logic [15:0] OE_MAP = 16'hE4E2;
  logic        clock_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rdata;
  logic        avs_waitrequest;
  logic        cd = 1'b0, rxg = 1'b1, txg = 1'b1, tx_slot = 1'b1, strb = 1'b1, strb_on = 1'b0;
  logic        fs = 1'b0, ots = 1'b0, ors = 1'b0, run = 1'b0, cnt_on = 1'b0;
  logic        rxp, txm, xt, tx_out, tx_oe, xo, rbe, tbe, rsy, tsy, cdo;
  logic [4:0]  prv;
  int          error_cnt, checks_done, n_rx, n_tx, n_a, n_t, n_x, n_o, n_p, n_rs, n_ts;
  wire  logic  txp = tx_oe ? tx_out : (strb_on ? strb : txm);
  // 20 MHz clock
  always #25 clock_in = !clock_in;
  scm_pin_source u_scm_pin_source (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .run_in(run), .rx_clk_out(rxp), .tx_clk_out(txm), .xtal_out(xt));
  scm_clock_mode_select u_scm_clock_mode_select (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_clock_pin_in(rxp), .tx_clock_pin_in(txp),
    .tx_clock_pin_out(tx_out), .tx_clock_pin_oe_out(tx_oe), .crystal_in_pin_in(xt),
    .crystal_out_pin_out(xo), .carrier_detect_pin_in(cd), .rx_gate_pin_in(rxg),
    .tx_gate_pin_in(txg), .frame_sync_pin_in(fs), .tx_octet_sync_pin_in(ots),
    .rx_octet_sync_pin_in(ors), .rx_data_pin_in(1'b0), .rx_slot_active_in(1'b1),
    .tx_slot_active_in(tx_slot), .rx_bit_en_out(rbe), .tx_bit_en_out(tbe),
    .rx_sync_out(rsy), .tx_sync_out(tsy), .carrier_detect_out(cdo));
  // Pulse and pin-edge counts inside a window
  always @(posedge clock_in) begin
    prv <= {rxp, txm, xt, xo, tx_out};
    if (cnt_on) begin
      n_rx += rbe;
      n_tx += tbe;
      n_rs += rsy;
      n_ts += tsy;
      n_a += rxp && !prv[4];
      n_t += txm && !prv[3];
      n_x += xt && !prv[2];
      n_o += xo && !prv[1];
      n_p += tx_out && !prv[0];
    end
  end
  task automatic print_verdict;
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %0d, want %0d", $time, seen, exp);
    end
  endtask
  // Count compare, slack of two
  task automatic near(input int seen, input int exp);
    check((seen > exp + 2 || seen + 2 < exp) ? seen : exp, exp);
  endtask
  // Avalon-MM access, held until waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clock_in); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic window(input int w);
    @(negedge clock_in);
    {n_rx, n_tx, n_a, n_t, n_x, n_o, n_p, n_rs, n_ts} = '0;
    cnt_on = 1'b1;
    repeat (w) @(negedge clock_in);
    cnt_on = 1'b0;
  endtask
  // Expected ticks by source: pins, crystal or divider chains
  function automatic int pick(input logic [3:0] s);
    case (s)
      4'h0: pick = n_a;
      4'h1: pick = n_t;
      4'h2: pick = n_x / 4;
      4'h3: pick = n_x / 64;
      4'h4: pick = n_a / 4;
      default: pick = n_a / 64;
    endcase
  endfunction
  // One pulse on chosen sync pins, count sync outputs
  task automatic sync_try(input logic [2:0] p, input int er, input int et);
    fork
      window(40);
      begin
        @(posedge clock_in) {fs, ots, ors} <= p;
        repeat (4) @(posedge clock_in);
        {fs, ots, ors} <= 3'h0;
      end
    join
    check(n_rs, er);
    check(n_ts, et);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    run <= 1'b1;
    bus(1'b0, OFS_CONFIG, 0);
    check(rdata[2:0], RST_MODE);
    bus(1'b0, OFS_GLOBAL, 0);
    check(rdata[FLD_OSC_PD], RST_OSCILLATOR_POWERDOWN_BIT);
    bus(1'b0, OFS_RATIO, 0);
    bus(1'b1, 4'h2, 32'h0000_00FF);
    bus(1'b0, 4'h2, 0);
    check(rdata, 0);
    window(64);
    check(n_o, 0);
    bus(1'b1, OFS_GLOBAL, 0);
    bus(1'b1, OFS_RATIO, 1);
    window(64);
    near(n_o, n_x);
    cd <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      strb_on <= (m / 2 == 1);
      bus(1'b1, OFS_CONFIG, 32'(16 + 8 * (m % 2) + m / 2));
      repeat (16) @(posedge clock_in);
      window(2048);
      near(n_rx, pick(RX_MAP[4*m +: 4]));
      near(n_tx, pick(TX_MAP[4*m +: 4]));
      check(tx_oe, OE_MAP[m]);
      check(cdo, !(m / 2 inside {1, 4, 5}));
      if (OE_MAP[m] && m != 10) near(n_p, n_tx);
    end
    bus(1'b1, OFS_CONFIG, 32'h0000_0015);
    repeat (8) @(posedge clock_in);
    check(tx_out, 1'b0);
    tx_slot <= 1'b0;
    repeat (8) @(posedge clock_in);
    check(tx_out, 1'b1);
    tx_slot <= 1'b1;
    sync_try(3'h4, 1, 1);
    sync_try(3'h3, 0, 0);
    bus(1'b1, OFS_CONFIG, 32'h0000_001D);
    sync_try(3'h1, 1, 0);
    sync_try(3'h2, 0, 1);
    strb_on <= 1'b1;
    strb <= 1'b0;
    cd <= 1'b0;
    bus(1'b1, OFS_CONFIG, 32'h0000_0001);
    window(256);
    check(n_rx, 0);
    check(n_tx, 0);
    bus(1'b1, OFS_CONFIG, 32'h0000_0021);
    fork
      window(200);
      begin
        @(negedge rxp);
        @(posedge clock_in) cd <= 1'b1;
        repeat (2) @(posedge clock_in);
        cd <= 1'b0;
      end
    join
    check(n_rx, BYTE_BITS);
    strb_on <= 1'b0;
    bus(1'b1, OFS_CONFIG, 32'h0000_0004);
    for (int g = 1; g < 3; g++) begin
      {rxg, txg} <= 2'(g);
      repeat (8) @(posedge clock_in);
      window(256);
      near(g[1] ? n_rx : n_tx, g[1] ? n_a : n_t);
      check(g[1] ? n_tx : n_rx, 0);
    end
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clock_in);
    error_cnt++;
    print_verdict();
  end
endmodule // scm_clock_mode_select_tb
